//--- common/cbi_pkg.sv
package cbi_pkg;
   // Timing in nanoseconds, turned into 100 MHz cycle counts
   localparam int CLK_NS = 10;
   localparam int CPU_PERIOD_NS = 250;
   localparam int CPU_HIGH_NS = 125;
   localparam int PHI1_NS = 62;
   localparam int PSYNC_NS = 125;
   localparam int CPU_PERIOD_CYC = CPU_PERIOD_NS / CLK_NS;
   localparam int CPU_HIGH_CYC = (CPU_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int PHI1_CYC = (PHI1_NS + CLK_NS - 1) / CLK_NS;
   localparam int PSYNC_CYC = (PSYNC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] CPU_PERIOD_C = 6'(CPU_PERIOD_CYC);
   localparam logic [5:0] CPU_HIGH_C = 6'(CPU_HIGH_CYC);
   localparam logic [5:0] PHI1_START_C = 6'(CPU_HIGH_CYC + 1);
   localparam logic [5:0] PHI1_END_C = 6'(CPU_HIGH_CYC + 1 + PHI1_CYC);
   localparam logic [5:0] PSYNC_C = 6'(PSYNC_CYC);
   // One forced wait spans two processor periods so the wait sample lands inside it
   localparam logic [5:0] WAIT1_C = 6'(2 * CPU_PERIOD_CYC);
   localparam logic [5:0] CNT_ONE = 6'h01;
   localparam logic [5:0] CNT_ZERO = 6'h00;

   // Opcodes fed to the processor
   localparam logic [7:0] OP_JP = 8'hC3;
   localparam logic [7:0] OP_RST0 = 8'hC7;
   localparam logic [7:0] DI_IDLE = 8'hFF;

   // Power-on jump progress
   localparam logic [1:0] JMP_OPC = 2'h0;
   localparam logic [1:0] JMP_LO = 2'h1;
   localparam logic [1:0] JMP_HI = 2'h2;
   localparam logic [1:0] JMP_DONE = 2'h3;

   typedef enum logic [1:0] {
      CYC_IDLE = 2'b01,
      CYC_BUSY = 2'b10
   } cbi_cyc_e;
endpackage

//--- core/cbi_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module cbi_clkgen (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Generated clocks
   output logic cpu_clock_o,
   output logic phi1_o,
   output logic phi2_o,
   output logic clk2m_n_o
);
   import cbi_pkg::*;

   logic [5:0] ph_cnt;
   logic half;
   wire logic wrap;
   wire logic [5:0] next_ph_cnt;
   wire logic next_half;

   assign wrap = (ph_cnt == CPU_PERIOD_C - CNT_ONE);
   assign next_ph_cnt = wrap ? CNT_ZERO : ph_cnt + CNT_ONE;
   assign next_half = wrap ? !half : half;

   // Registered so every clock leaves glitch free
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         // Start at the wrap point so the first high pulse is full width
         ph_cnt <= CPU_PERIOD_C - CNT_ONE;
         half <= 1'b1;
         cpu_clock_o <= 1'b0;
         phi1_o <= 1'b0;
         phi2_o <= 1'b0;
         clk2m_n_o <= 1'b1;
      end else begin
         ph_cnt <= next_ph_cnt;
         half <= next_half;
         cpu_clock_o <= (next_ph_cnt < CPU_HIGH_C);
         phi2_o <= (next_ph_cnt < CPU_HIGH_C);
         phi1_o <= (next_ph_cnt >= PHI1_START_C) && (next_ph_cnt < PHI1_END_C);
         clk2m_n_o <= next_half;
      end
   end
endmodule
`default_nettype wire

//--- core/cbi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cbi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '1
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Pins in, synchronised out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= INIT;
         q_o <= INIT;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

//--- core/cbi_top.sv
`timescale 1ns/1ps
`default_nettype none
module cbi_top (
   // Clock and backplane reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Jumper options
   input wire logic [15:0] power_on_jump_i,
   input wire logic one_wait_option_i,
   input wire logic port_addr_copy_option_i,
   input wire logic vector_logic_disable_i,
   input wire logic write_strobe_drive_option_i,
   // Processor pins in
   input wire logic cpu_m1_n_i,
   input wire logic cpu_mreq_n_i,
   input wire logic cpu_iorq_n_i,
   input wire logic cpu_rd_n_i,
   input wire logic cpu_wr_n_i,
   input wire logic cpu_rfsh_n_i,
   input wire logic cpu_halt_n_i,
   input wire logic cpu_busak_n_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic [7:0] cpu_data_out_i,
   // Processor pins out
   output logic cpu_clock_o,
   output logic cpu_reset_n_o,
   output logic cpu_wait_n_o,
   output logic cpu_int_n_o,
   output logic [7:0] cpu_data_in_o,
   // Backplane inputs
   input wire logic bus_ready_i,
   input wire logic [7:0] bus_vi_n_i,
   input wire logic [7:0] bus_data_in_i,
   // Backplane clocks and reset
   output logic bus_phi1_o,
   output logic bus_phi2_o,
   output logic bus_clk2m_n_o,
   output logic poc_n_o,
   // Backplane address and data
   output logic [15:0] bus_addr_o,
   output logic [7:0] bus_data_out_o,
   // Backplane strobes and status
   output logic psync_o,
   output logic pdbin_o,
   output logic pwr_n_o,
   output logic mwrite_o,
   output logic pmreq_n_o,
   output logic prfsh_n_o,
   output logic sm1_o,
   output logic smemr_o,
   output logic sout_o,
   output logic sinp_o,
   output logic swo_n_o,
   output logic shlta_o,
   output logic phlda_o,
   output logic pwait_o,
   output logic run_o
);
   import cbi_pkg::*;

   localparam int SW = 69;

   function automatic logic [2:0] prio_lvl(input logic [7:0] req);
      logic [2:0] lvl;
      lvl = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (req[i]) begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction

   logic [SW-1:0] s_q;
   wire logic [15:0] s_pj;
   wire logic s_ow, s_am, s_vdis, s_mw;
   wire logic s_m1_n, s_mreq_n, s_iorq_n, s_rd_n, s_wr_n, s_rfsh_n, s_halt_n, s_busak_n;
   wire logic [15:0] s_addr;
   wire logic [7:0] s_dout, s_vi_n, s_di;
   wire logic s_ready;

   // Every input pin except clock and reset, including jumpers, passes two flops first
   cbi_sync #(.W(SW), .INIT({SW{1'b1}})) u_sync (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({power_on_jump_i, one_wait_option_i, port_addr_copy_option_i,
            vector_logic_disable_i, write_strobe_drive_option_i,
            cpu_m1_n_i, cpu_mreq_n_i, cpu_iorq_n_i, cpu_rd_n_i, cpu_wr_n_i,
            cpu_rfsh_n_i, cpu_halt_n_i, cpu_busak_n_i, cpu_addr_i,
            cpu_data_out_i, bus_ready_i, bus_vi_n_i, bus_data_in_i}),
      .q_o(s_q)
   );
   assign {s_pj, s_ow, s_am, s_vdis, s_mw, s_m1_n, s_mreq_n, s_iorq_n, s_rd_n,
           s_wr_n, s_rfsh_n, s_halt_n, s_busak_n, s_addr, s_dout, s_ready,
           s_vi_n, s_di} = s_q;

   cbi_clkgen u_clkgen (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .cpu_clock_o(cpu_clock_o),
      .phi1_o(bus_phi1_o),
      .phi2_o(bus_phi2_o),
      .clk2m_n_o(bus_clk2m_n_o)
   );

   // Decoded processor activity
   wire logic m1, mreq, iorq, rd, wr, rfsh;
   wire logic mem_acc, acc_act, int_ack, any_act, cyc_start, read_end, acc_start;
   assign m1 = !s_m1_n;
   assign mreq = !s_mreq_n;
   assign iorq = !s_iorq_n;
   assign rd = !s_rd_n;
   assign wr = !s_wr_n;
   assign rfsh = !s_rfsh_n;
   assign mem_acc = mreq && !rfsh;
   assign acc_act = mem_acc || iorq;
   assign int_ack = m1 && iorq;
   assign any_act = m1 || acc_act;

   logic any_act_q, acc_act_q, rd_q;
   cbi_cyc_e cyc_st;
   wire cbi_cyc_e next_cyc_st;
   assign cyc_start = any_act && !any_act_q;
   assign acc_start = acc_act && !acc_act_q;
   assign read_end = rd_q && !rd;
   assign next_cyc_st = any_act ? CYC_BUSY : CYC_IDLE;

   // Status captured at cycle start; a memory or port cycle without read is marked as a write at once
   wire logic next_st_memr, next_st_mwr, next_st_inp, next_st_out;
   assign next_st_memr = m1 || (mem_acc && rd);
   assign next_st_mwr = mem_acc && !rd && !m1;
   assign next_st_inp = iorq && rd && !m1;
   assign next_st_out = iorq && !rd && !m1;
   logic st_write;

   // Sync pulse counter
   logic [5:0] pcnt;
   wire logic [5:0] next_pcnt;
   assign next_pcnt = cyc_start ? PSYNC_C : ((pcnt != CNT_ZERO) ? pcnt - CNT_ONE : CNT_ZERO);

   // Wait generation
   logic [5:0] wcnt;
   wire logic [5:0] next_wcnt;
   wire logic next_wait_n;
   assign next_wcnt = (acc_start && s_ow) ? WAIT1_C
                    : ((wcnt != CNT_ZERO) ? wcnt - CNT_ONE : CNT_ZERO);
   assign next_wait_n = !((acc_act && !s_ready) || (next_wcnt != CNT_ZERO));

   // Data into the processor
   logic [1:0] jump_phase;
   wire logic [7:0] jump_byte, vec_op, next_di;
   wire logic [7:0] vi_pend;
   wire logic vec_ok;
   assign jump_byte = (jump_phase == JMP_OPC) ? OP_JP
                    : ((jump_phase == JMP_LO) ? s_pj[7:0] : s_pj[15:8]);
   assign vi_pend = ~s_vi_n;
   assign vec_ok = !s_vdis && (vi_pend != 8'h00);
   assign vec_op = OP_RST0 | {2'h0, prio_lvl(vi_pend), 3'h0};
   // Bus pull-ups make an empty data-in bus read as restart 7
   assign next_di = (jump_phase != JMP_DONE) ? jump_byte
                  : ((int_ack && !s_vdis) ? vec_op : s_di);

   wire logic [15:0] next_addr;
   assign next_addr = (iorq && s_am) ? {s_addr[7:0], s_addr[7:0]} : s_addr;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cpu_reset_n_o <= 1'b0;
         poc_n_o <= 1'b0;
      end else begin
         cpu_reset_n_o <= 1'b1;
         poc_n_o <= 1'b1;
      end
   end

   // Jump bytes are counted by completed reads, so slow memories do not matter
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         jump_phase <= JMP_OPC;
      end else if (read_end && jump_phase != JMP_DONE) begin
         jump_phase <= jump_phase + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         any_act_q <= 1'b0;
         acc_act_q <= 1'b0;
         rd_q <= 1'b0;
         cyc_st <= CYC_IDLE;
         pcnt <= CNT_ZERO;
         wcnt <= CNT_ZERO;
      end else begin
         any_act_q <= any_act;
         acc_act_q <= acc_act;
         // Memory read remembered, since the read and request strobes end together
         rd_q <= rd && mreq;
         cyc_st <= next_cyc_st;
         pcnt <= next_pcnt;
         wcnt <= next_wcnt;
      end
   end

   // Latched cycle status
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sm1_o <= 1'b0;
         sinp_o <= 1'b0;
         sout_o <= 1'b0;
         st_write <= 1'b0;
         smemr_o <= 1'b0;
      end else begin
         case (cyc_st)
            CYC_IDLE: begin
               if (cyc_start) begin
                  sm1_o <= m1 && !iorq;
                  sinp_o <= next_st_inp;
                  sout_o <= next_st_out;
                  st_write <= next_st_mwr || next_st_out;
                  smemr_o <= next_st_memr;
               end
            end
            CYC_BUSY: begin
               if (!any_act) begin
                  sm1_o <= 1'b0;
                  sinp_o <= 1'b0;
                  sout_o <= 1'b0;
                  st_write <= 1'b0;
                  smemr_o <= 1'b0;
               end else if (mem_acc && rd && !m1) begin
                  smemr_o <= 1'b1;
               end else if (mem_acc && wr) begin
                  st_write <= 1'b1;
               end
            end
            default: begin
               sm1_o <= 1'b0;
               smemr_o <= 1'b0;
            end
         endcase
      end
   end

   // Strobes follow the processor three flops late, one flop after the synchroniser
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         psync_o <= 1'b0;
         pdbin_o <= 1'b0;
         pwr_n_o <= 1'b1;
         mwrite_o <= 1'b0;
         pmreq_n_o <= 1'b1;
         prfsh_n_o <= 1'b1;
         swo_n_o <= 1'b1;
         shlta_o <= 1'b0;
         phlda_o <= 1'b0;
         pwait_o <= 1'b0;
         run_o <= 1'b0;
         cpu_wait_n_o <= 1'b1;
         cpu_int_n_o <= 1'b1;
         cpu_data_in_o <= DI_IDLE;
         bus_addr_o <= 16'h0000;
         bus_data_out_o <= 8'h00;
      end else begin
         psync_o <= (next_pcnt != CNT_ZERO);
         pdbin_o <= rd && acc_act;
         pwr_n_o <= !wr;
         mwrite_o <= wr && mem_acc && s_mw;
         pmreq_n_o <= !mreq;
         prfsh_n_o <= !(rfsh && mreq);
         swo_n_o <= !(st_write && wr);
         shlta_o <= !s_halt_n;
         phlda_o <= !s_busak_n;
         pwait_o <= !next_wait_n;
         run_o <= s_halt_n;
         cpu_wait_n_o <= next_wait_n;
         cpu_int_n_o <= !vec_ok;
         cpu_data_in_o <= next_di;
         bus_addr_o <= next_addr;
         bus_data_out_o <= s_dout;
      end
   end

   // Run lengths for clock width checks
   logic [5:0] clk_run, phi1_run;
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clk_run <= CNT_ZERO;
         phi1_run <= CNT_ZERO;
      end else begin
         clk_run <= cpu_clock_o ? clk_run + CNT_ONE : CNT_ZERO;
         phi1_run <= bus_phi1_o ? phi1_run + CNT_ONE : CNT_ZERO;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   chk_cpu_clk_width: assert property ($fell(cpu_clock_o) |-> clk_run == CPU_HIGH_C)
      else $error("processor clock high width wrong");
   chk_phi1_width: assert property ($fell(bus_phi1_o) |-> phi1_run == 6'(PHI1_CYC))
      else $error("phase one width wrong");
   chk_clk2m_low: assert property ($fell(bus_clk2m_n_o) |-> ##25 $rose(bus_clk2m_n_o))
      else $error("2 MHz clock low time wrong");
   chk_reset_release: assert property (!cpu_reset_n_o |=> cpu_reset_n_o && poc_n_o)
      else $error("reset outputs not released");
   chk_jump_opcode: assert property ((cpu_reset_n_o && jump_phase == JMP_OPC) |=> cpu_data_in_o == OP_JP)
      else $error("jump opcode not supplied");
   chk_wait_ready: assert property ((acc_act && !s_ready) |=> !cpu_wait_n_o && pwait_o)
      else $error("ready low did not hold wait");
   chk_one_wait: assert property ((acc_start && s_ow) |=> (!cpu_wait_n_o) [*8])
      else $error("forced wait state missing");
   chk_idle_bus: assert property ((jump_phase == JMP_DONE && !int_ack && s_di == DI_IDLE)
      |=> cpu_data_in_o == DI_IDLE)
      else $error("idle data-in not all ones");
   chk_vector: assert property ((jump_phase == JMP_DONE && int_ack && !s_vdis && vi_pend[0])
      |=> cpu_data_in_o == OP_RST0)
      else $error("wrong restart vector");
   chk_psync_width: assert property ($rose(psync_o) |-> psync_o [*8] ##5 psync_o ##1 !psync_o)
      else $error("sync pulse width wrong");
   chk_status_hold: assert property ((any_act && !cyc_start && cyc_st == CYC_BUSY)
      |=> $stable(sm1_o) && $stable(sinp_o) && $stable(sout_o))
      else $error("status changed inside cycle");
   chk_mirror_addr: assert property ((iorq && s_am) |=> bus_addr_o[15:8] == bus_addr_o[7:0])
      else $error("port address not mirrored");
   chk_mwrite_gate: assert property (!s_mw |=> !mwrite_o)
      else $error("write strobe driven while disabled");
   chk_refresh_req: assert property ((mreq && rfsh) |=> !prfsh_n_o && !pmreq_n_o)
      else $error("refresh strobes missing");

   cov_jump_done: cover property ($rose(jump_phase == JMP_DONE));
   cov_int_ack: cover property (int_ack && vec_ok);
   cov_ready_wait: cover property (acc_act && !s_ready);
   cov_mem_write: cover property (mwrite_o && !swo_n_o);
endmodule
`default_nettype wire

//--- verif/cbi_backplane.sv
`timescale 1ns/1ps
`default_nettype none
module cbi_backplane (
   // Clock
   input wire logic ref_clk_i,
   // Scenario controls
   input wire logic stall_i,
   input wire logic [7:0] req_i,
   input wire logic drive_i,
   input wire logic [7:0] byte_i,
   // Strobe from the card
   input wire logic pdbin_i,
   // Lines into the card
   output logic bus_ready_o,
   output logic [7:0] bus_vi_n_o,
   output logic [7:0] bus_data_in_o
);
   initial begin
      bus_ready_o = 1'b1;
      bus_vi_n_o = 8'hFF;
      bus_data_in_o = 8'hFF;
   end
   always @(posedge ref_clk_i) begin
      bus_ready_o <= !stall_i;
      bus_vi_n_o <= ~req_i;
      // Pull-ups win whenever no board answers the read strobe
      bus_data_in_o <= (drive_i && pdbin_i) ? byte_i : 8'hFF;
   end
endmodule
`default_nettype wire

//--- verif/test_cbi_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_cbi_top;
   import cbi_pkg::*;
   localparam logic [5:0] FETCH = 6'h34;
   localparam logic [5:0] RD = 6'h14;
   localparam logic [5:0] WR = 6'h12;
   localparam logic [5:0] RF = 6'h11;
   localparam logic [5:0] IN = 6'h0C;
   localparam logic [5:0] OUT = 6'h0A;
   localparam logic [5:0] ACK = 6'h28;
   logic ref_clk_i = 1'b0, arst_n_i = 1'b0;
   logic [15:0] power_on_jump_i = 16'hE800, cpu_addr_i = 16'h0000;
   logic one_wait_option_i = 1'b0, port_addr_copy_option_i = 1'b1;
   logic vector_logic_disable_i = 1'b0, write_strobe_drive_option_i = 1'b1;
   logic cpu_m1_n_i = 1'b1, cpu_mreq_n_i = 1'b1, cpu_iorq_n_i = 1'b1, cpu_rd_n_i = 1'b1;
   logic cpu_wr_n_i = 1'b1, cpu_rfsh_n_i = 1'b1, cpu_halt_n_i = 1'b1, cpu_busak_n_i = 1'b1;
   logic [7:0] cpu_data_out_i = 8'h00, cpu_data_in_o, bus_data_out_o, bus_vi_n_i, bus_data_in_i;
   logic bus_ready_i, cpu_clock_o, cpu_reset_n_o, cpu_wait_n_o, cpu_int_n_o;
   logic bus_phi1_o, bus_phi2_o, bus_clk2m_n_o, poc_n_o, psync_o, pdbin_o, pwr_n_o, mwrite_o;
   logic pmreq_n_o, prfsh_n_o, sm1_o, smemr_o, sout_o, sinp_o, swo_n_o, shlta_o, phlda_o;
   logic pwait_o, run_o, stall = 1'b0, drive = 1'b0;
   logic [15:0] bus_addr_o;
   logic [7:0] req = 8'h00, rom_byte = 8'h3E;
   int failures = 0, compares = 0, cycles = 0, run_len = 0, psync_w = 0, psync_n = 0;

   always #5 ref_clk_i = ~ref_clk_i;

   cbi_top dut (.ref_clk_i, .arst_n_i, .power_on_jump_i, .one_wait_option_i,
      .port_addr_copy_option_i, .vector_logic_disable_i, .write_strobe_drive_option_i,
      .cpu_m1_n_i, .cpu_mreq_n_i, .cpu_iorq_n_i, .cpu_rd_n_i, .cpu_wr_n_i, .cpu_rfsh_n_i,
      .cpu_halt_n_i, .cpu_busak_n_i, .cpu_addr_i, .cpu_data_out_i, .cpu_clock_o, .cpu_reset_n_o,
      .cpu_wait_n_o, .cpu_int_n_o, .cpu_data_in_o, .bus_ready_i, .bus_vi_n_i, .bus_data_in_i,
      .bus_phi1_o, .bus_phi2_o, .bus_clk2m_n_o, .poc_n_o, .bus_addr_o, .bus_data_out_o,
      .psync_o, .pdbin_o, .pwr_n_o, .mwrite_o, .pmreq_n_o, .prfsh_n_o, .sm1_o, .smemr_o,
      .sout_o, .sinp_o, .swo_n_o, .shlta_o, .phlda_o, .pwait_o, .run_o);

   cbi_backplane boards (.ref_clk_i, .stall_i(stall), .req_i(req), .drive_i(drive),
      .byte_i(rom_byte), .pdbin_i(pdbin_o), .bus_ready_o(bus_ready_i),
      .bus_vi_n_o(bus_vi_n_i), .bus_data_in_o(bus_data_in_i));

   // Width and count of sync pulses, seen from the bus side
   always @(negedge ref_clk_i) begin
      if (psync_o === 1'b1) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         psync_w <= run_len;
         psync_n <= psync_n + 1;
         run_len <= 0;
      end
   end

   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk_bit(input string what, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Lows order: m1 mreq iorq rd wr rfsh
   task automatic access(input logic [5:0] lows, input logic [15:0] a, input logic [7:0] d, input int hold);
      @(posedge ref_clk_i);
      {cpu_m1_n_i, cpu_mreq_n_i, cpu_iorq_n_i, cpu_rd_n_i, cpu_wr_n_i, cpu_rfsh_n_i} <= ~lows;
      cpu_addr_i <= a;
      cpu_data_out_i <= d;
      repeat (hold) @(negedge ref_clk_i);
   endtask

   task automatic idle();
      access(6'h00, cpu_addr_i, cpu_data_out_i, 8);
   endtask

   task automatic test_reset();
      repeat (2) @(negedge ref_clk_i);
      chk_bit("cpu_reset_n in reset", 1'b0, cpu_reset_n_o);
      chk_bit("poc_n in reset", 1'b0, poc_n_o);
      @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(negedge ref_clk_i);
      chk_bit("cpu_reset_n released", 1'b1, cpu_reset_n_o);
      chk_bit("poc_n released", 1'b1, poc_n_o);
      $display("test reset done");
   endtask

   task automatic test_clocks();
      int hi, p1, lo2, diff;
      hi = 0;
      p1 = 0;
      lo2 = 0;
      diff = 0;
      for (int i = 0; i < 2 * CPU_PERIOD_CYC; i++) begin
         @(negedge ref_clk_i);
         hi = hi + int'(cpu_clock_o === 1'b1);
         p1 = p1 + int'(bus_phi1_o === 1'b1);
         lo2 = lo2 + int'(bus_clk2m_n_o === 1'b0);
         diff = diff + int'(bus_phi2_o !== cpu_clock_o);
      end
      chk_vec("cpu clock high cycles", 16'(2 * CPU_HIGH_CYC), 16'(hi));
      chk_vec("phi2 differs", 16'h0000, 16'(diff));
      chk_vec("phi1 high cycles", 16'(2 * PHI1_CYC), 16'(p1));
      chk_vec("2 MHz clock low cycles", 16'(CPU_PERIOD_CYC), 16'(lo2));
      $display("test clocks done");
   endtask

   task automatic test_jump();
      access(FETCH, 16'h0000, 8'h00, 20);
      chk_vec("jump opcode", {8'h00, OP_JP}, {8'h00, cpu_data_in_o});
      idle();
      chk_vec("psync width", 16'(PSYNC_CYC), 16'(psync_w));
      access(RD, 16'h0001, 8'h00, 20);
      chk_vec("jump low byte", {8'h00, power_on_jump_i[7:0]}, {8'h00, cpu_data_in_o});
      chk_bit("sm1 on plain read", 1'b0, sm1_o);
      idle();
      access(RD, 16'h0002, 8'h00, 20);
      chk_vec("jump high byte", {8'h00, power_on_jump_i[15:8]}, {8'h00, cpu_data_in_o});
      idle();
      stall <= 1'b1;
      access(FETCH, power_on_jump_i, 8'h00, 20);
      chk_bit("wait_n held", 1'b0, cpu_wait_n_o);
      chk_bit("pwait held", 1'b1, pwait_o);
      chk_bit("sm1 steady in wait", 1'b1, sm1_o);
      chk_vec("address steady in wait", power_on_jump_i, bus_addr_o);
      stall <= 1'b0;
      repeat (6) @(negedge ref_clk_i);
      chk_bit("wait_n released", 1'b1, cpu_wait_n_o);
      idle();
      $display("test jump done");
   endtask

   task automatic test_loop();
      int n0;
      n0 = psync_n;
      access(FETCH, 16'h0038, 8'h00, 20);
      chk_vec("undriven data in", 16'h00FF, {8'h00, cpu_data_in_o});
      chk_bit("sm1", 1'b1, sm1_o);
      chk_bit("smemr", 1'b1, smemr_o);
      chk_bit("pdbin", 1'b1, pdbin_o);
      chk_bit("pmreq_n fetch", 1'b0, pmreq_n_o);
      access(RF, 16'h0012, 8'h00, 8);
      chk_bit("prfsh_n", 1'b0, prfsh_n_o);
      chk_bit("pmreq_n refresh", 1'b0, pmreq_n_o);
      idle();
      for (int i = 0; i < 2; i++) begin
         access(WR, 16'h1FFE - 16'(i), i == 0 ? 8'h00 : 8'h39, 20);
         chk_vec("pushed byte", {8'h00, i == 0 ? 8'h00 : 8'h39}, {8'h00, bus_data_out_o});
         chk_bit("mwrite", 1'b1, mwrite_o);
         chk_bit("pwr_n", 1'b0, pwr_n_o);
         chk_bit("swo_n", 1'b0, swo_n_o);
         chk_bit("smemr on write", 1'b0, smemr_o);
         idle();
      end
      chk_vec("sync pulses per loop", 16'h0003, 16'(psync_n - n0));
      drive <= 1'b1;
      access(FETCH, 16'h0039, 8'h00, 20);
      chk_vec("driven data in", {8'h00, rom_byte}, {8'h00, cpu_data_in_o});
      drive <= 1'b0;
      idle();
      // Another board owns the write strobe
      @(posedge ref_clk_i);
      write_strobe_drive_option_i <= 1'b0;
      access(WR, 16'h1FFC, 8'h00, 20);
      chk_bit("mwrite disabled", 1'b0, mwrite_o);
      chk_bit("pwr_n option off", 1'b0, pwr_n_o);
      @(posedge ref_clk_i);
      write_strobe_drive_option_i <= 1'b1;
      idle();
      $display("test loop done");
   endtask

   task automatic test_status();
      int lows;
      chk_vec("idle status", 16'h0001, {10'h000, phlda_o, pwait_o, sout_o, sinp_o, shlta_o, run_o});
      @(posedge ref_clk_i);
      cpu_halt_n_i <= 1'b0;
      cpu_busak_n_i <= 1'b0;
      idle();
      chk_vec("halt and hold", 16'h0022, {10'h000, phlda_o, pwait_o, sout_o, sinp_o, shlta_o, run_o});
      @(posedge ref_clk_i);
      cpu_halt_n_i <= 1'b1;
      cpu_busak_n_i <= 1'b1;
      idle();
      access(IN, 16'h3412, 8'h00, 20);
      chk_vec("mirrored port", 16'h1212, bus_addr_o);
      chk_bit("sinp", 1'b1, sinp_o);
      idle();
      @(posedge ref_clk_i);
      port_addr_copy_option_i <= 1'b0;
      access(OUT, 16'h3412, 8'h5A, 20);
      chk_vec("plain port", 16'h3412, bus_addr_o);
      chk_bit("sout", 1'b1, sout_o);
      idle();
      @(posedge ref_clk_i);
      one_wait_option_i <= 1'b1;
      access(RD, 16'h0100, 8'h00, 1);
      lows = 0;
      for (int i = 0; i < 70; i++) begin
         @(negedge ref_clk_i);
         lows = lows + int'(cpu_wait_n_o === 1'b0);
      end
      chk_bit("forced wait", 1'b1, lows > 0 && lows <= 50);
      @(posedge ref_clk_i);
      one_wait_option_i <= 1'b0;
      idle();
      $display("test status done");
   endtask

   task automatic test_vector();
      foreach (req[lvl]) begin
         req <= 8'h80 | (8'h01 << lvl);
         repeat (6) @(negedge ref_clk_i);
         chk_bit("int_n raised", 1'b0, cpu_int_n_o);
         access(ACK, 16'h0000, 8'h00, 20);
         chk_vec("restart vector", {8'h00, OP_RST0 | 8'(lvl << 3)}, {8'h00, cpu_data_in_o});
         idle();
      end
      @(posedge ref_clk_i);
      vector_logic_disable_i <= 1'b1;
      repeat (6) @(negedge ref_clk_i);
      chk_bit("int_n disabled", 1'b1, cpu_int_n_o);
      access(ACK, 16'h0000, 8'h00, 20);
      chk_vec("disabled ack passes bus", 16'h00FF, {8'h00, cpu_data_in_o});
      idle();
      @(posedge ref_clk_i);
      req <= 8'h00;
      vector_logic_disable_i <= 1'b0;
      idle();
      $display("test vector done");
   endtask

   initial begin
      test_reset();
      test_jump();
      test_clocks();
      test_loop();
      test_status();
      test_vector();
      end_sim();
   end
endmodule
`default_nettype wire
